//--- rtl/phy_clk_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
module phy_clk_pin_mux (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire phy_clk_pin_pkg::clk_src_t clk_src,
    input  wire phy_clk_pin_pkg::aux_src_t aux_src,
    input  wire logic [1:0]                link_speed,
    input  wire logic [4:0]                trim_code,
    output logic                           clk_out,
    output logic                           clk_out_oe,
    output logic                           aux0_out,
    output logic                           aux1_out,
    output logic      [4:0]                impedance_code
);
    logic [8:0]                src_lvl;
    phy_clk_pin_pkg::clk_src_t lvl_s;
    logic [4:0]                clk_sel_ff;
    logic                      clk_dis_ff;
    logic [4:0]                imp_ff;
    logic                      trim_done_ff;
    logic [3:0]                aux0_sel_ff;
    logic [3:0]                aux1_sel_ff;
    logic [31:0]               prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    logic                      clk_out_ff;
    logic                      clk_out_oe_ff;
    logic                      aux0_ff;
    logic                      aux1_ff;
    logic [3:0]                rx_prev_ff;
    logic [2:0]                div_cnt_ff [4];
    logic [3:0]                div_lvl;
    logic                      nxt_clk_out;
    logic                      energy_ok;
    logic                      wr_io;
    logic                      wr_aux;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // -------------------------------------------------------------
    // clock source synchronisers
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_sync
            pin_sync3 u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (clk_src[gi]),
                .dout    (src_lvl[gi])
            );
        end
    endgenerate
    assign lvl_s = phy_clk_pin_pkg::clk_src_t'(src_lvl);

    // -------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == phy_clk_pin_pkg::IO_CFG_ADDR) || (a == phy_clk_pin_pkg::AUX_SEL_ADDR);
    endfunction : addr_hit

    assign wr_io  = psel && penable && pready_ff && pwrite
                    && (paddr == phy_clk_pin_pkg::IO_CFG_ADDR);
    assign wr_aux = psel && penable && pready_ff && pwrite
                    && (paddr == phy_clk_pin_pkg::AUX_SEL_ADDR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !addr_hit(paddr);
        end
    end

    // reserved bits are never stored and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= 32'h0000_0000;
            if (paddr == phy_clk_pin_pkg::IO_CFG_ADDR) begin
                prdata_ff[phy_clk_pin_pkg::CLK_SEL_MSB:phy_clk_pin_pkg::CLK_SEL_LSB]
                    <= clk_sel_ff;
                prdata_ff[phy_clk_pin_pkg::CLK_DIS_BIT] <= clk_dis_ff;
                prdata_ff[phy_clk_pin_pkg::IMP_MSB:phy_clk_pin_pkg::IMP_LSB] <= imp_ff;
            end else if (paddr == phy_clk_pin_pkg::AUX_SEL_ADDR) begin
                prdata_ff[phy_clk_pin_pkg::AUX1_MSB:phy_clk_pin_pkg::AUX1_LSB]
                    <= aux1_sel_ff;
                prdata_ff[phy_clk_pin_pkg::AUX0_MSB:phy_clk_pin_pkg::AUX0_LSB]
                    <= aux0_sel_ff;
            end
        end
    end

    // -------------------------------------------------------------
    // clock output configuration
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_ff <= phy_clk_pin_pkg::CLK_SEL_RST;
            clk_dis_ff <= phy_clk_pin_pkg::CLK_DIS_RST;
        end else if (wr_io) begin
            clk_sel_ff <= pwdata[phy_clk_pin_pkg::CLK_SEL_MSB:phy_clk_pin_pkg::CLK_SEL_LSB];
            clk_dis_ff <= pwdata[phy_clk_pin_pkg::CLK_DIS_BIT];
        end
    end

    // impedance code caught from trim on the first edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imp_ff       <= 5'h00;
            trim_done_ff <= 1'b0;
        end else if (!trim_done_ff) begin
            imp_ff       <= trim_code;
            trim_done_ff <= 1'b1;
        end else if (wr_io) begin
            imp_ff <= pwdata[phy_clk_pin_pkg::IMP_MSB:phy_clk_pin_pkg::IMP_LSB];
        end
    end

    // -------------------------------------------------------------
    // auxiliary select configuration
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux1_sel_ff <= phy_clk_pin_pkg::AUX_SEL_RST;
            aux0_sel_ff <= phy_clk_pin_pkg::AUX_SEL_RST;
        end else if (wr_aux) begin
            aux1_sel_ff <= pwdata[phy_clk_pin_pkg::AUX1_MSB:phy_clk_pin_pkg::AUX1_LSB];
            aux0_sel_ff <= pwdata[phy_clk_pin_pkg::AUX0_MSB:phy_clk_pin_pkg::AUX0_LSB];
        end
    end

    // -------------------------------------------------------------
    // receive clock divide by five
    // -------------------------------------------------------------
    generate
        for (gi = 0; gi < 4; gi++) begin : g_div
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_prev_ff[gi] <= 1'b0;
                    div_cnt_ff[gi] <= 3'h0;
                end else begin
                    rx_prev_ff[gi] <= lvl_s.rx[gi];
                    if (lvl_s.rx[gi] && !rx_prev_ff[gi]) begin
                        if (div_cnt_ff[gi] == phy_clk_pin_pkg::DIV_LAST) begin
                            div_cnt_ff[gi] <= 3'h0;
                        end else begin
                            div_cnt_ff[gi] <= div_cnt_ff[gi] + 3'h1;
                        end
                    end
                end
            end
            assign div_lvl[gi] = (div_cnt_ff[gi] < phy_clk_pin_pkg::DIV_HIGH);
        end
    endgenerate

    // -------------------------------------------------------------
    // clock output mux
    // -------------------------------------------------------------
    always_comb begin
        case (clk_sel_ff) inside
            [phy_clk_pin_pkg::CLK_SEL_RX_A:phy_clk_pin_pkg::CLK_SEL_RX_D]:
                nxt_clk_out = lvl_s.rx[clk_sel_ff[1:0]];
            [phy_clk_pin_pkg::CLK_SEL_RXDIV_A:phy_clk_pin_pkg::CLK_SEL_RXDIV_D]:
                nxt_clk_out = div_lvl[clk_sel_ff[1:0]];
            [phy_clk_pin_pkg::CLK_SEL_TX_A:phy_clk_pin_pkg::CLK_SEL_TX_D]:
                nxt_clk_out = lvl_s.tx[clk_sel_ff[1:0]];
            phy_clk_pin_pkg::CLK_SEL_REF:
                nxt_clk_out = lvl_s.ref_clk;
            default:
                nxt_clk_out = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_ff    <= 1'b0;
            clk_out_oe_ff <= 1'b0;
        end else begin
            clk_out_ff    <= nxt_clk_out && !clk_dis_ff;
            clk_out_oe_ff <= !clk_dis_ff;
        end
    end

    // -------------------------------------------------------------
    // auxiliary pin mux
    // -------------------------------------------------------------
    function automatic logic aux_pick(
        input logic [3:0]                sel,
        input logic                      dflt,
        input phy_clk_pin_pkg::aux_src_t s,
        input logic                      ed_ok
    );
        case (sel)
            phy_clk_pin_pkg::AUX_DEFAULT: aux_pick = dflt;
            phy_clk_pin_pkg::AUX_TX_SOF:  aux_pick = s.tx_sof;
            phy_clk_pin_pkg::AUX_RX_SOF:  aux_pick = s.rx_sof;
            phy_clk_pin_pkg::AUX_WAKE:    aux_pick = s.wake;
            phy_clk_pin_pkg::AUX_ENERGY:  aux_pick = s.energy && ed_ok;
            phy_clk_pin_pkg::AUX_LED3:    aux_pick = s.led3;
            phy_clk_pin_pkg::AUX_PRBS:    aux_pick = s.prbs_err;
            phy_clk_pin_pkg::AUX_CONST0:  aux_pick = 1'b0;
            phy_clk_pin_pkg::AUX_CONST1:  aux_pick = 1'b1;
            default:                      aux_pick = 1'b0;
        endcase
    endfunction : aux_pick

    assign energy_ok = (link_speed == phy_clk_pin_pkg::SPEED_1000)
                       || (link_speed == phy_clk_pin_pkg::SPEED_100);

    // each pin has its own flop, but one write to AUX_SEL_ADDR loads both selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux0_ff <= 1'b0;
        end else begin
            aux0_ff <= aux_pick(aux0_sel_ff, aux_src.rx_err, aux_src, energy_ok);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux1_ff <= 1'b0;
        end else begin
            aux1_ff <= aux_pick(aux1_sel_ff, aux_src.collision, aux_src, energy_ok);
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign clk_out        = clk_out_ff;
    assign clk_out_oe     = clk_out_oe_ff;
    assign aux0_out       = aux0_ff;
    assign aux1_out       = aux1_ff;
    assign impedance_code = imp_ff;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    a_ref_clk_route: assert property (
        (clk_sel_ff == phy_clk_pin_pkg::CLK_SEL_REF && !clk_dis_ff)
        |=> clk_out_ff == $past(lvl_s.ref_clk))
        else $error("reference clock not routed");

    a_clk_reserved: assert property (
        (clk_sel_ff > phy_clk_pin_pkg::CLK_SEL_REF) |=> !clk_out_ff)
        else $error("reserved clock select drove the pin");

    a_tx_clk_route: assert property (
        (clk_sel_ff[4:2] == 3'h2 && !clk_dis_ff)
        |=> clk_out_ff == $past(lvl_s.tx[clk_sel_ff[1:0]]))
        else $error("transmit clock not routed");

    a_div_wrap: assert property (
        (lvl_s.rx[0] && !rx_prev_ff[0] && div_cnt_ff[0] == 3'h4)
        |=> div_cnt_ff[0] == 3'h0)
        else $error("divide by five did not wrap");

    a_div_route: assert property (
        (clk_sel_ff[4:2] == 3'h1 && !clk_dis_ff)
        |=> clk_out_ff == ($past(div_cnt_ff[clk_sel_ff[1:0]]) < 3'h2))
        else $error("divided receive clock not routed");

    a_rx_clk_route: assert property (
        (clk_sel_ff[4:2] == 3'h0 && !clk_dis_ff)
        |=> clk_out_ff == $past(lvl_s.rx[clk_sel_ff[1:0]]))
        else $error("receive clock not routed");

    a_clk_disable: assert property (
        clk_dis_ff |=> !clk_out_oe_ff && !clk_out_ff)
        else $error("clock pin driven while disabled");

    a_trim_load: assert property (
        $rose(trim_done_ff) |-> imp_ff == $past(trim_code))
        else $error("impedance not loaded from trim");

    a_aux_reserved: assert property (
        (aux0_sel_ff > phy_clk_pin_pkg::AUX_CONST1) |=> !aux0_ff)
        else $error("reserved auxiliary select drove the pin");

    a_aux_const: assert property (
        (aux1_sel_ff == phy_clk_pin_pkg::AUX_CONST1) [*2] |-> aux1_ff)
        else $error("constant one not driven");

    a_energy_gate: assert property (
        (aux0_sel_ff == phy_clk_pin_pkg::AUX_ENERGY && !energy_ok) |=> !aux0_ff)
        else $error("energy detect passed at wrong speed");

    a_aux_default: assert property (
        (aux1_sel_ff == phy_clk_pin_pkg::AUX_DEFAULT)
        |=> aux1_ff == $past(aux_src.collision))
        else $error("collision not routed");

    a_rx_a_route: assert property (
        (clk_sel_ff == phy_clk_pin_pkg::CLK_SEL_RX_A && !clk_dis_ff)
        |=> clk_out_ff == $past(lvl_s.rx[0]))
        else $error("channel A receive clock not routed");

    a_aux_zero: assert property (
        (aux0_sel_ff == phy_clk_pin_pkg::AUX_CONST0) |=> !aux0_ff)
        else $error("constant zero not driven");

    a_aux_led: assert property (
        (aux0_sel_ff == phy_clk_pin_pkg::AUX_LED3)
        |=> aux0_ff == $past(aux_src.led3))
        else $error("third led signal not routed");

    a_aux_prbs: assert property (
        (aux1_sel_ff == phy_clk_pin_pkg::AUX_PRBS)
        |=> aux1_ff == $past(aux_src.prbs_err))
        else $error("prbs error not routed");

    a_aux_wake: assert property (
        (aux1_sel_ff == phy_clk_pin_pkg::AUX_WAKE)
        |=> aux1_ff == $past(aux_src.wake))
        else $error("wake indication not routed");

    a_rx_err_route: assert property (
        (aux0_sel_ff == phy_clk_pin_pkg::AUX_DEFAULT)
        |=> aux0_ff == $past(aux_src.rx_err))
        else $error("receive error not routed");

    a_rsvd_read: assert property (
        (psel && !penable && !pwrite && paddr == phy_clk_pin_pkg::IO_CFG_ADDR)
        |=> prdata_ff[15:13] == 3'h0 && !prdata_ff[7] && !prdata_ff[5])
        else $error("reserved bits read nonzero");

    c_sel_tx: cover property (wr_io ##1 clk_sel_ff == phy_clk_pin_pkg::CLK_SEL_TX_A);
    c_div_wrap: cover property (div_cnt_ff[0] == 3'h4 ##[1:20] div_cnt_ff[0] == 3'h0);
    c_disable: cover property ($rose(clk_dis_ff));
    c_aux_write: cover property (wr_aux ##1 aux0_sel_ff == phy_clk_pin_pkg::AUX_CONST1);

endmodule : phy_clk_pin_mux
`default_nettype wire

//--- rtl/phy_clk_pin_pkg.sv
package phy_clk_pin_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [11:0] IO_CFG_IDX  = 12'h170;
    localparam logic [11:0] AUX_SEL_IDX = 12'h172;
    localparam logic [11:0] IO_CFG_ADDR  = IO_CFG_IDX << 2;
    localparam logic [11:0] AUX_SEL_ADDR = AUX_SEL_IDX << 2;

    localparam int CLK_SEL_LSB = 8;
    localparam int CLK_SEL_MSB = 12;
    localparam int CLK_DIS_BIT = 6;
    localparam int IMP_LSB     = 0;
    localparam int IMP_MSB     = 4;
    localparam int AUX1_LSB    = 4;
    localparam int AUX1_MSB    = 7;
    localparam int AUX0_LSB    = 0;
    localparam int AUX0_MSB    = 3;

    localparam logic [4:0] CLK_SEL_RST = 5'h0C;
    localparam logic       CLK_DIS_RST = 1'b0;
    localparam logic [3:0] AUX_SEL_RST = 4'h0;

    // -------------------------------------------------------------
    // clock select codes
    // -------------------------------------------------------------
    localparam logic [4:0] CLK_SEL_RX_A    = 5'h00;
    localparam logic [4:0] CLK_SEL_RX_D    = 5'h03;
    localparam logic [4:0] CLK_SEL_RXDIV_A = 5'h04;
    localparam logic [4:0] CLK_SEL_RXDIV_D = 5'h07;
    localparam logic [4:0] CLK_SEL_TX_A    = 5'h08;
    localparam logic [4:0] CLK_SEL_TX_D    = 5'h0B;
    localparam logic [4:0] CLK_SEL_REF     = 5'h0C;

    // -------------------------------------------------------------
    // auxiliary select codes
    // -------------------------------------------------------------
    localparam logic [3:0] AUX_DEFAULT = 4'h0;
    localparam logic [3:0] AUX_TX_SOF  = 4'h1;
    localparam logic [3:0] AUX_RX_SOF  = 4'h2;
    localparam logic [3:0] AUX_WAKE    = 4'h3;
    localparam logic [3:0] AUX_ENERGY  = 4'h4;
    localparam logic [3:0] AUX_LED3    = 4'h6;
    localparam logic [3:0] AUX_PRBS    = 4'h7;
    localparam logic [3:0] AUX_CONST0  = 4'h8;
    localparam logic [3:0] AUX_CONST1  = 4'h9;

    // -------------------------------------------------------------
    // divider and speed codes
    // -------------------------------------------------------------
    localparam logic [2:0] DIV_LAST = 3'h4;
    localparam logic [2:0] DIV_HIGH = 3'h2;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    typedef struct packed {
        logic       ref_clk;
        logic [3:0] tx;
        logic [3:0] rx;
    } clk_src_t;

    typedef struct packed {
        logic rx_err;
        logic collision;
        logic tx_sof;
        logic rx_sof;
        logic wake;
        logic energy;
        logic led3;
        logic prbs_err;
    } aux_src_t;

endpackage : phy_clk_pin_pkg

//--- rtl/pin_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;

    // -------------------------------------------------------------
    // three stages, level moves once stages two and three agree
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
        end
    end

    assign dout = lvl_ff;
endmodule : pin_sync3
`default_nettype wire

//--- verif/board_pin_probe.sv
`timescale 1ns/10ps
`default_nettype none
module board_pin_probe (
    input  wire logic        pclk,
    input  wire logic        clr,
    input  wire logic        clk_out,
    input  wire logic        clk_out_oe,
    output logic             pin_level,
    output logic [15:0]      period,
    output logic [15:0]      hi_time,
    output logic [15:0]      edges
);
    // ------------------------------------------------------------
    // pin net seen by the board, no pull: undriven shows inverse
    // ------------------------------------------------------------
    logic        last_ff;
    logic        prev_ff;
    logic [15:0] run_ff;
    logic [15:0] high_ff;

    always_comb pin_level = clk_out_oe ? clk_out : ~last_ff;

    // ------------------------------------------------------------
    // period, high time and rising edge count of the pin
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (clk_out_oe) last_ff <= clk_out;
        else if (clr) last_ff <= 1'h0;
        prev_ff <= pin_level;
        if (clr) begin
            run_ff  <= 16'h0000;
            high_ff <= 16'h0000;
            edges   <= 16'h0000;
            period  <= 16'h0000;
            hi_time <= 16'h0000;
        end else if (pin_level === 1'h1 && prev_ff === 1'h0) begin
            period  <= run_ff;
            hi_time <= high_ff;
            run_ff  <= 16'h0001;
            high_ff <= 16'h0001;
            edges   <= edges + 16'h0001;
        end else begin
            run_ff  <= run_ff + 16'h0001;
            high_ff <= high_ff + {15'h0000, pin_level};
        end
    end
endmodule : board_pin_probe
`default_nettype wire

//--- verif/test_phy_clock_and_aux_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
module test_phy_clock_and_aux_pin_mux;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    phy_clk_pin_pkg::clk_src_t clk_src;
    phy_clk_pin_pkg::aux_src_t aux_src;
    logic [1:0]  link_speed;
    logic [4:0]  trim_code, impedance_code;
    logic clk_out, clk_out_oe, aux0_out, aux1_out, pin_level;
    logic [15:0] period, hi_time, edges;
    int n_errors, samples_checked, cycles, idx, dv;
    int cnt [9];
    localparam logic [11:0] IO = phy_clk_pin_pkg::IO_CFG_ADDR;
    localparam logic [11:0] AX = phy_clk_pin_pkg::AUX_SEL_ADDR;

    phy_clk_pin_mux DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_src(clk_src), .aux_src(aux_src), .link_speed(link_speed),
        .trim_code(trim_code), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
        .aux0_out(aux0_out), .aux1_out(aux1_out), .impedance_code(impedance_code));
    board_pin_probe u_probe (.pclk(pclk), .clr(clr), .clk_out(clk_out),
        .clk_out_oe(clk_out_oe), .pin_level(pin_level), .period(period),
        .hi_time(hi_time), .edges(edges));

    // ------------------------------------------------------------
    // clocks: source i toggles every 12-i cycles
    // ------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        for (int i = 0; i < 9; i++) begin
            if (cnt[i] >= 11 - i) begin
                cnt[i] <= 0;
                clk_src[i] <= ~clk_src[i];
            end else cnt[i] <= cnt[i] + 1;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) n_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    function automatic logic exp_aux(input logic p, input logic [3:0] c, input logic [1:0] s);
        case (c)
            phy_clk_pin_pkg::AUX_DEFAULT: exp_aux = p ? aux_src.collision : aux_src.rx_err;
            phy_clk_pin_pkg::AUX_TX_SOF:  exp_aux = aux_src.tx_sof;
            phy_clk_pin_pkg::AUX_RX_SOF:  exp_aux = aux_src.rx_sof;
            phy_clk_pin_pkg::AUX_WAKE:    exp_aux = aux_src.wake;
            phy_clk_pin_pkg::AUX_ENERGY:  exp_aux = aux_src.energy &
                (s == phy_clk_pin_pkg::SPEED_100 || s == phy_clk_pin_pkg::SPEED_1000);
            phy_clk_pin_pkg::AUX_LED3:    exp_aux = aux_src.led3;
            phy_clk_pin_pkg::AUX_PRBS:    exp_aux = aux_src.prbs_err;
            phy_clk_pin_pkg::AUX_CONST1:  exp_aux = 1'h1;
            default:                      exp_aux = 1'h0;
        endcase
    endfunction : exp_aux

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, link_speed} = '0;
        clk_src = '0;
        aux_src = '0;
        clr = 1'h1;
        trim_code = 5'h13;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        clr <= 1'h0;
        repeat (3) @(posedge pclk);
        check(32'(clk_out_oe), 32'h1);
        check(32'(impedance_code), 32'h13);
        apb(1'h0, IO, 32'h0);
        check(r, 32'h00000C13);
        apb(1'h0, AX, 32'h0);
        check(r, 32'h0);
        apb(1'h1, IO, 32'hFFFFFFFF);
        apb(1'h0, IO, 32'h0);
        check(r, 32'h00001F5F);
        check(32'(impedance_code), 32'h1F);
        apb(1'h1, IO, 32'h0);
        @(posedge pclk);
        check(32'(impedance_code), 32'h0);
        apb(1'h1, AX, 32'hFFFFFFFF);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h000, 32'h0);
        check({r[30:0], e}, 32'h1);
        apb(1'h0, AX, 32'h0);
        check(r, 32'h000000FF);
        for (int c = 0; c < 32; c++) begin
            apb(1'h1, IO, 32'(c) << 8);
            clr <= 1'h1;
            @(posedge pclk);
            clr <= 1'h0;
            repeat (c < 13 ? 420 : 60) @(posedge pclk);
            idx = c < 4 ? c : c - 4;
            dv = (c >= 4 && c < 8) ? 5 : 1;
            if (c < 13) check({period, hi_time}, {16'(24 - 2 * idx) * 16'(dv),
                16'(12 - idx) * 16'(dv == 5 ? 4 : 1)});
            else check({edges, 15'h0, clk_out}, 32'h0);
        end
        apb(1'h1, IO, 32'h00000C40);
        repeat (3) @(posedge pclk);
        check({clk_out_oe, clk_out}, 32'h0);
        apb(1'h1, IO, 32'h00000C00);
        repeat (3) @(posedge pclk);
        check(32'(clk_out_oe), 32'h1);
        for (int s = 0; s < 4; s++) begin
            link_speed <= 2'(s);
            for (int c = 0; c < 16; c++) begin
                apb(1'h1, AX, 32'(c) * 32'h11);
                for (int b = 0; b < 16; b++) begin
                    aux_src <= b < 8 ? 8'(1 << b) : ~8'(1 << (b - 8));
                    repeat (2) @(posedge pclk);
                    check({aux1_out, aux0_out}, {exp_aux(1'h1, 4'(c), 2'(s)),
                        exp_aux(1'h0, 4'(c), 2'(s))});
                end
            end
        end
        apb(1'h1, AX, 32'h00000089);
        repeat (2) @(posedge pclk);
        check({aux1_out, aux0_out}, 32'h1);
        stop_test();
    end
endmodule : test_phy_clock_and_aux_pin_mux
`default_nettype wire
